// *** src/intercept_pkg.sv ***
// What this block does
// [RULE1] capture guest bytes on nested/intercepted page fault
// [RULE2] capture up to fifteen bytes, fifteen without fault
// [RULE3] fetch fault keeps only bytes already fetched
// [RULE4] count in bits 3:0, bits 7:4 zero
// [RULE5] fill only for data-access page faults
// [RULE6] other intercepts clear the count byte
// [RULE7] status register intercept checked by five ops
// [RULE8] non-memory faults first; word ops before memory
// [RULE9] page base: non-memory faults before intercept
// [RULE10] page base write intercept precedes cache flush
// [RULE11] pointer entry fault checked after intercept
// [RULE12] implicit page base accesses never intercepted
// [RULE13] other control regs: exceptions before intercept
// [RULE14] debug regs: exceptions first, implicit unchecked
// [RULE15] selective write fires only on other bits
// [RULE16] both enabled reports non-selective intercept
// [RULE17] selective has generic write priority
// [RULE18] load word treats selective as non-selective
// [RULE19] table regs: after opcode/protection, before memory
// [RULE20] intercept abandons instruction, exits to host
package intercept_pkg;

	localparam logic [11:0] CAPTURE_OFFSET = 12'h0d0;
	localparam int          CAPTURE_BITS   = 128;
	localparam int          MAX_BYTES      = 15;
	localparam int          COUNT_LSB      = 0;
	localparam int          COUNT_MSB      = 3;
	localparam int          BYTES_LSB      = 8;
	localparam int          TS_BIT         = 3;
	localparam int          MP_BIT         = 1;
	localparam logic [3:0]  COUNT_ZERO     = 4'h0;

	// instruction classes seen by the check
	typedef enum logic [3:0] {
		OP_NONE, OP_MOV_TO_MS, OP_MOV_FROM_MS, OP_LOAD_WORD, OP_STORE_WORD,
		OP_CLEAR_TS, OP_MOV_TO_PTB, OP_MOV_FROM_PTB, OP_MOV_OTHER_CR,
		OP_MOV_DEBUG, OP_TABLE_REG
	} op_class_t;

	// outcome of the priority resolution
	typedef enum logic [3:0] {
		RES_NONE, RES_EXC_PRE, RES_EXIT_MS_WRITE, RES_EXIT_MS_SEL,
		RES_EXIT_MS_READ, RES_EXIT_PTB_WRITE, RES_EXIT_PTB_READ,
		RES_EXIT_OTHER_CR, RES_EXIT_DEBUG, RES_EXIT_TABLE, RES_EXC_POST
	} result_t;

endpackage

// *** src/capture_if.sv ***
// carries fetched bytes from the fetch tracker to the capture field
interface capture_if;
	logic       start;
	logic       byte_valid;
	logic [7:0] byte_data;
	logic       fetch_fault;
	logic       done;
	logic [3:0] count;
	logic [119:0] bytes;
	modport tracker (input start, byte_valid, byte_data, fetch_fault,
		output done, count, bytes);
	modport top (output start, byte_valid, byte_data, fetch_fault,
		input done, count, bytes);
endinterface

// *** src/byte_fetch_tracker.sv ***
module byte_fetch_tracker
	import intercept_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	capture_if.tracker cap
);
	logic [3:0]   cnt_reg;
	logic         busy_reg;
	logic [119:0] bytes_reg;
	logic         done_reg;

	wire   take = busy_reg & cap.byte_valid & ~cap.fetch_fault;
	wire   full = take & (cnt_reg == 4'(MAX_BYTES - 1)); // RULE2
	wire   stop = busy_reg & (cap.fetch_fault | full); // RULE3

	// count bytes until fifteen or a fetch fault
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_reg   <= 4'h0;
			busy_reg  <= 1'b0;
			bytes_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= stop;
			if (cap.start) begin
				cnt_reg  <= 4'h0;
				busy_reg <= 1'b1;
			end else begin
				if (take) begin
					bytes_reg[cnt_reg*8 +: 8] <= cap.byte_data;
					cnt_reg                   <= cnt_reg + 4'h1;
				end
				if (stop)
					busy_reg <= 1'b0;
			end
		end
	end

	assign cap.done  = done_reg;
	assign cap.count = cnt_reg;
	assign cap.bytes = bytes_reg;

	// a plain bound on a four-bit count holds by construction, so watch the stop
	chk_count_limit: assert property (@(posedge i_core_clk) disable iff (i_reset)
		busy_reg && full && !cap.start |=> !busy_reg && cnt_reg == 4'(MAX_BYTES))
		else $error("fetch did not stop at fifteen"); // RULE2
	chk_fault_freeze: assert property (@(posedge i_core_clk) disable iff (i_reset)
		busy_reg && cap.fetch_fault && !cap.start |=> cnt_reg == $past(cnt_reg))
		else $error("count moved on fetch fault"); // RULE3
endmodule // byte_fetch_tracker

// *** src/guest_intercept_check_and_capture.sv ***
module guest_intercept_check_and_capture
	import intercept_pkg::*;
(
	input  wire logic         i_core_clk,
	input  wire logic         i_reset,
	input  wire logic         i_check_valid,
	input  wire op_class_t    i_op,
	input  wire logic         i_is_write,
	input  wire logic         i_implicit,
	input  wire logic         i_nonmem_fault,
	input  wire logic         i_mem_fault,
	input  wire logic         i_page_dir_pointer_entry_fault,
	input  wire logic         i_ext_phys_addr,
	input  wire logic [31:0]  i_ms_old,
	input  wire logic [31:0]  i_ms_new,
	input  wire logic         i_en_ms_read,
	input  wire logic         i_en_ms_write,
	input  wire logic         i_en_ms_sel,
	input  wire logic         i_en_ptb_read,
	input  wire logic         i_en_ptb_write,
	input  wire logic         i_en_other_cr,
	input  wire logic         i_en_debug,
	input  wire logic         i_en_table,
	input  wire logic         i_pf_exit,
	input  wire logic         i_pf_is_fetch,
	input  wire logic         i_other_exit,
	input  wire logic         i_byte_valid,
	input  wire logic [7:0]   i_byte_data,
	input  wire logic         i_fetch_fault,
	input  wire logic [11:0]  i_rd_offset,
	output logic              o_result_valid,
	output result_t           o_result,
	output logic              o_guest_exit,
	output logic              o_abandon,
	output logic              o_allow_flush,
	output logic              o_allow_mem,
	output logic              o_fetch_req,
	output logic              o_capture_write,
	output logic [127:0]      o_rd_data
);

	////////////////////////////////////////////////////////////////
	// intercept enables per op class
	wire ms_write_op = (i_op == OP_MOV_TO_MS) | (i_op == OP_LOAD_WORD)
		| (i_op == OP_CLEAR_TS); // RULE7
	wire ms_read_op  = (i_op == OP_MOV_FROM_MS) | (i_op == OP_STORE_WORD); // RULE7
	wire word_op     = (i_op == OP_LOAD_WORD) | (i_op == OP_STORE_WORD);
	wire [31:0] ms_diff = i_ms_old ^ i_ms_new;
	wire [31:0] sel_mask = ~((32'h1 << TS_BIT) | (32'h1 << MP_BIT));
	wire other_bits_change = |(ms_diff & sel_mask); // RULE15
	// clear-task-switched only touches the ts bit, so selective never fires
	wire sel_hit = i_en_ms_sel & (i_op != OP_CLEAR_TS)
		& ((i_op == OP_LOAD_WORD) | other_bits_change); // RULE15 RULE18
	wire ms_write_hit = ms_write_op & i_en_ms_write; // RULE16
	wire ms_sel_hit   = ms_write_op & ~i_en_ms_write & sel_hit; // RULE16 RULE17
	wire ms_read_hit  = ms_read_op & i_en_ms_read;
	wire ptb_op       = (i_op == OP_MOV_TO_PTB) | (i_op == OP_MOV_FROM_PTB);
	// implicit page base traffic from entry, exit or task switch is exempt
	wire ptb_w_hit    = (i_op == OP_MOV_TO_PTB) & i_en_ptb_write & ~i_implicit; // RULE12
	wire ptb_r_hit    = (i_op == OP_MOV_FROM_PTB) & i_en_ptb_read & ~i_implicit; // RULE12
	wire cr_hit       = (i_op == OP_MOV_OTHER_CR) & i_en_other_cr;
	wire dbg_hit      = (i_op == OP_MOV_DEBUG) & i_en_debug & ~i_implicit; // RULE14
	wire tbl_hit      = (i_op == OP_TABLE_REG) & i_en_table;
	wire any_hit = ms_write_hit | ms_sel_hit | ms_read_hit | ptb_w_hit | ptb_r_hit
		| cr_hit | dbg_hit | tbl_hit;

	////////////////////////////////////////////////////////////////
	// exceptions checked ahead of the intercept differ by class
	// other cr and debug: all normal exceptions, memory ones included
	wire all_first  = (i_op == OP_MOV_OTHER_CR) | (i_op == OP_MOV_DEBUG); // RULE13 RULE14
	wire pre_exc    = i_nonmem_fault | (all_first & i_mem_fault); // RULE8 RULE9 RULE19
	// word ops and table ops: memory faults only after the intercept
	wire ptb_page_dir_pointer_entry   = i_ext_phys_addr & i_page_dir_pointer_entry_fault & (i_op == OP_MOV_TO_PTB); // RULE11
	wire post_exc   = (~all_first & i_mem_fault) | ptb_page_dir_pointer_entry;
	wire exit_now   = ~pre_exc & any_hit; // RULE20

	result_t res_next;
	always_comb begin
		res_next = RES_NONE;
		if (pre_exc)
			res_next = RES_EXC_PRE;
		else if (ms_write_hit)
			res_next = RES_EXIT_MS_WRITE; // RULE16
		else if (ms_sel_hit)
			res_next = RES_EXIT_MS_SEL;
		else if (ms_read_hit)
			res_next = RES_EXIT_MS_READ;
		else if (ptb_w_hit)
			res_next = RES_EXIT_PTB_WRITE;
		else if (ptb_r_hit)
			res_next = RES_EXIT_PTB_READ;
		else if (cr_hit)
			res_next = RES_EXIT_OTHER_CR;
		else if (dbg_hit)
			res_next = RES_EXIT_DEBUG;
		else if (tbl_hit)
			res_next = RES_EXIT_TABLE;
		else if (post_exc)
			res_next = RES_EXC_POST; // RULE11
	end

	// flush and memory access only when no exit or earlier fault
	wire flush_ok = i_check_valid & (i_op == OP_MOV_TO_PTB) & ~pre_exc & ~exit_now
		& ~post_exc; // RULE10
	wire mem_ok   = i_check_valid & (word_op | (i_op == OP_TABLE_REG)) & ~pre_exc
		& ~exit_now; // RULE8 RULE19

	// decision register, one pulse per check
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_result_valid <= 1'b0;
			o_result       <= RES_NONE;
			o_guest_exit   <= 1'b0;
			o_abandon      <= 1'b0;
			o_allow_flush  <= 1'b0;
			o_allow_mem    <= 1'b0;
		end else begin
			o_result_valid <= i_check_valid;
			o_result       <= i_check_valid ? res_next : RES_NONE;
			o_guest_exit   <= i_check_valid & exit_now; // RULE20
			o_abandon      <= i_check_valid & (exit_now | pre_exc | post_exc);
			o_allow_flush  <= flush_ok;
			o_allow_mem    <= mem_ok;
		end
	end

	////////////////////////////////////////////////////////////////
	// capture field and byte fetch
	capture_if cap ();
	byte_fetch_tracker u_tracker (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.cap        (cap)
	);

	wire data_pf = i_pf_exit & ~i_pf_is_fetch; // RULE1 RULE5
	assign cap.start       = data_pf;
	assign cap.byte_valid  = i_byte_valid;
	assign cap.byte_data   = i_byte_data;
	assign cap.fetch_fault = i_fetch_fault;

	logic [127:0] field_reg;
	logic         pending_reg;

	// field updated at fetch end; other exits clear the count byte
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			field_reg       <= '0;
			pending_reg     <= 1'b0;
			o_fetch_req     <= 1'b0;
			o_capture_write <= 1'b0;
		end else begin
			o_capture_write <= 1'b0;
			if (data_pf) begin
				pending_reg <= 1'b1;
				o_fetch_req <= 1'b1;
			end else if (pending_reg && cap.done) begin
				pending_reg     <= 1'b0;
				o_fetch_req     <= 1'b0;
				field_reg[127:BYTES_LSB] <= cap.bytes; // RULE1
				field_reg[7:0] <= {4'h0, cap.count}; // RULE4
				o_capture_write <= 1'b1;
			end else if (i_other_exit || (i_pf_exit && i_pf_is_fetch)) begin
				field_reg[7:0]  <= 8'h00; // RULE6 RULE5
				o_capture_write <= 1'b1;
			end
		end
	end

	// read port of the control block field
	wire hit_rd = (i_rd_offset == CAPTURE_OFFSET);
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			o_rd_data <= '0;
		else
			o_rd_data <= hit_rd ? field_reg : '0;
	end

	////////////////////////////////////////////////////////////////
	chk_nonsel_wins: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && !pre_exc && ms_write_op && i_en_ms_write
		|=> o_result == RES_EXIT_MS_WRITE) else $error("non-selective not reported"); // RULE16
	chk_clear_task_switched_op_nosel: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && i_op == OP_CLEAR_TS && !i_en_ms_write
		|=> !o_guest_exit) else $error("clear ts took selective exit"); // RULE15
	chk_ptb_before_flush: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_guest_exit |-> !o_allow_flush && !o_allow_mem) else $error("side effect on exit"); // RULE10
	chk_implicit_ptb: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && ptb_op && i_implicit
		|=> !o_guest_exit) else $error("implicit page base intercepted"); // RULE12
	chk_exc_first: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && i_nonmem_fault |=> o_result == RES_EXC_PRE && !o_guest_exit)
		else $error("intercept beat non-memory fault"); // RULE8
	chk_other_cr_mem: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && all_first && i_mem_fault |=> !o_guest_exit)
		else $error("intercept beat memory fault"); // RULE13
	chk_word_mem: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_check_valid && !i_nonmem_fault && i_op == OP_LOAD_WORD && i_en_ms_write
		|=> o_guest_exit) else $error("load word exit missed"); // RULE8
	chk_count_bits: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_capture_write |-> field_reg[7:4] == 4'h0) else $error("count high bits set"); // RULE4
	chk_other_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_other_exit && !data_pf && !(pending_reg && cap.done)
		|=> field_reg[7:0] == 8'h00) else $error("count byte not cleared"); // RULE6

	cov_sel_exit: cover property (@(posedge i_core_clk) o_result == RES_EXIT_MS_SEL);
	cov_full_fetch: cover property (@(posedge i_core_clk)
		o_capture_write && field_reg[3:0] == 4'(MAX_BYTES));
	cov_page_dir_pointer_entry_post: cover property (@(posedge i_core_clk) o_result == RES_EXC_POST);
	cov_table_exit: cover property (@(posedge i_core_clk) o_result == RES_EXIT_TABLE);

endmodule // guest_intercept_check_and_capture

// *** tb/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import intercept_pkg::*;

	typedef struct {
		op_class_t   op;
		logic [12:0] f;
		logic [31:0] ms_new;
		result_t     exp;
		bit          any;
	} row_t;

	logic         i_core_clk, i_reset, i_check_valid, i_is_write, i_implicit;
	logic         i_nonmem_fault, i_mem_fault, i_page_dir_pointer_entry_fault, i_ext_phys_addr;
	logic         i_en_ms_read, i_en_ms_write, i_en_ms_sel, i_en_ptb_read, i_en_ptb_write;
	logic         i_en_other_cr, i_en_debug, i_en_table, i_pf_exit, i_pf_is_fetch;
	logic         i_other_exit, i_byte_valid, i_fetch_fault;
	logic [7:0]   i_byte_data;
	logic [11:0]  i_rd_offset;
	logic [31:0]  i_ms_old, i_ms_new;
	op_class_t    i_op;
	result_t      o_result;
	logic         o_result_valid, o_guest_exit, o_abandon, o_allow_flush, o_allow_mem;
	logic         o_fetch_req, o_capture_write;
	logic [127:0] o_rd_data, d;
	int           n_errors, num_checks;

	// flag bits: nonmem mem page_dir_pointer_entry ext implicit msr msw sel ptbr ptbw other debug table
	row_t rows[20] = '{
		'{OP_MOV_TO_MS, 13'h1040, 32'h0, RES_EXC_PRE, 0},
		'{OP_MOV_TO_MS, 13'h0060, 32'h1, RES_EXIT_MS_WRITE, 0},
		'{OP_MOV_TO_MS, 13'h0020, 32'h8, RES_NONE, 0},
		'{OP_MOV_TO_MS, 13'h0020, 32'h1, RES_EXIT_MS_SEL, 0},
		'{OP_LOAD_WORD, 13'h0020, 32'h8, RES_NONE, 1},
		'{OP_CLEAR_TS, 13'h0020, 32'h0, RES_NONE, 0},
		'{OP_CLEAR_TS, 13'h0040, 32'h0, RES_EXIT_MS_WRITE, 0},
		'{OP_STORE_WORD, 13'h0880, 32'h0, RES_EXIT_MS_READ, 0},
		'{OP_MOV_FROM_MS, 13'h0080, 32'h0, RES_EXIT_MS_READ, 0},
		'{OP_MOV_TO_PTB, 13'h1008, 32'h0, RES_EXC_PRE, 0},
		'{OP_MOV_TO_PTB, 13'h0608, 32'h0, RES_EXIT_PTB_WRITE, 0},
		'{OP_MOV_TO_PTB, 13'h0600, 32'h0, RES_EXC_POST, 0},
		'{OP_MOV_TO_PTB, 13'h0108, 32'h0, RES_NONE, 0},
		'{OP_MOV_FROM_PTB, 13'h0010, 32'h0, RES_EXIT_PTB_READ, 0},
		'{OP_MOV_OTHER_CR, 13'h0804, 32'h0, RES_EXC_PRE, 0},
		'{OP_MOV_OTHER_CR, 13'h0004, 32'h0, RES_EXIT_OTHER_CR, 0},
		'{OP_MOV_DEBUG, 13'h0102, 32'h0, RES_NONE, 0},
		'{OP_MOV_DEBUG, 13'h0802, 32'h0, RES_EXC_PRE, 0},
		'{OP_TABLE_REG, 13'h0801, 32'h0, RES_EXIT_TABLE, 0},
		'{OP_TABLE_REG, 13'h1001, 32'h0, RES_EXC_PRE, 0}
	};

	guest_intercept_check_and_capture DUT (.i_core_clk, .i_reset, .i_check_valid, .i_op,
		.i_is_write, .i_implicit, .i_nonmem_fault, .i_mem_fault, .i_page_dir_pointer_entry_fault,
		.i_ext_phys_addr, .i_ms_old, .i_ms_new, .i_en_ms_read, .i_en_ms_write, .i_en_ms_sel,
		.i_en_ptb_read, .i_en_ptb_write, .i_en_other_cr, .i_en_debug, .i_en_table,
		.i_pf_exit, .i_pf_is_fetch, .i_other_exit, .i_byte_valid, .i_byte_data,
		.i_fetch_fault, .i_rd_offset, .o_result_valid, .o_result, .o_guest_exit,
		.o_abandon, .o_allow_flush, .o_allow_mem, .o_fetch_req, .o_capture_write,
		.o_rd_data);

	////////////////////////////////////////////////////////////////////////////////
	// clock at 25 ns
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	task automatic check(input string name, input logic [127:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// read lands one cycle late, so two edges are allowed before sampling
	task automatic read_field(input logic [11:0] off);
		@(posedge i_core_clk) i_rd_offset <= off;
		repeat (2) @(posedge i_core_clk);
		#1 d = o_rd_data;
	endtask

	// one page fault exit, then n bytes and optionally a fetch fault
	task automatic capture(input bit fetch, input int n, input bit flt, input logic [7:0] lo);
		logic [127:0] e, m;
		int           k;
		e = {120'h0, 4'h0, 4'(n)};
		m = 128'hff;
		@(posedge i_core_clk) i_pf_exit <= 1'b1;
		i_pf_is_fetch <= fetch;
		@(posedge i_core_clk) i_pf_exit <= 1'b0;
		#1 check("fetch_req", o_fetch_req, !fetch);
		for (k = 0; k < n; k++) begin
			@(posedge i_core_clk) i_byte_valid <= 1'b1;
			i_byte_data <= 8'h10 + 8'(k);
			e[8+8*k +: 8] = 8'h10 + 8'(k);
			m[8+8*k +: 8] = 8'hff;
		end
		@(posedge i_core_clk) i_byte_valid <= 1'b0;
		i_fetch_fault <= flt;
		@(posedge i_core_clk) i_fetch_fault <= 1'b0;
		#1;
		for (k = 0; k < 40 && !fetch && o_capture_write !== 1'b1; k++)
			@(posedge i_core_clk) #1;
		if (!fetch) begin
			check("capture_write", o_capture_write, 1'b1);
			read_field(12'h0d0);
			check("capture_field", d & m, e);
		end else begin
			read_field(12'h0d0);
			check("fetch_fault_field", d[7:0], lo);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: table rows first, then capture cases
	initial begin
		bit ex;
		{i_check_valid, i_is_write, i_implicit, i_nonmem_fault, i_mem_fault} = '0;
		{i_page_dir_pointer_entry_fault, i_ext_phys_addr, i_en_ms_read, i_en_ms_write, i_en_ms_sel} = '0;
		{i_en_ptb_read, i_en_ptb_write, i_en_other_cr, i_en_debug, i_en_table} = '0;
		{i_pf_exit, i_pf_is_fetch, i_other_exit, i_byte_valid, i_fetch_fault} = '0;
		{i_byte_data, i_rd_offset, i_ms_old, i_ms_new} = '0;
		i_op = OP_NONE;
		i_reset = 1'b1;
		repeat (5) @(posedge i_core_clk);
		i_reset <= 1'b0;
		#1 check("reset_result", o_result, RES_NONE);
		check("reset_exit", o_guest_exit, 1'b0);
		foreach (rows[i]) begin
			@(posedge i_core_clk) i_op <= rows[i].op;
			{i_nonmem_fault, i_mem_fault, i_page_dir_pointer_entry_fault, i_ext_phys_addr, i_implicit,
				i_en_ms_read, i_en_ms_write, i_en_ms_sel, i_en_ptb_read, i_en_ptb_write,
				i_en_other_cr, i_en_debug, i_en_table} <= rows[i].f;
			i_ms_new <= rows[i].ms_new;
			i_check_valid <= 1'b1;
			@(posedge i_core_clk) i_check_valid <= 1'b0;
			#1 ex = rows[i].any || rows[i].exp inside {[RES_EXIT_MS_WRITE:RES_EXIT_TABLE]};
			check("result_valid", o_result_valid, 1'b1);
			if (!rows[i].any)
				check("result", o_result, rows[i].exp);
			check("guest_exit", o_guest_exit, ex);
			check("abandon", o_abandon, ex || rows[i].exp inside {RES_EXC_PRE, RES_EXC_POST});
			check("allow_flush", o_allow_flush,
				rows[i].op == OP_MOV_TO_PTB && rows[i].exp == RES_NONE);
			check("allow_mem", o_allow_mem, !ex && rows[i].exp != RES_EXC_PRE
				&& rows[i].op inside {OP_LOAD_WORD, OP_STORE_WORD, OP_TABLE_REG});
		end
		capture(0, 15, 0, 8'h0);
		capture(1, 0, 0, 8'h00);
		capture(0, 0, 1, 8'h0);
		capture(0, 6, 1, 8'h0);
		@(posedge i_core_clk) i_other_exit <= 1'b1;
		@(posedge i_core_clk) i_other_exit <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		read_field(12'h0d0);
		check("other_exit_low", d[7:0], 8'h00);
		read_field(12'h0d8);
		check("unmapped_read", d, 128'h0);
		tally_and_finish();
	end

	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge i_core_clk);
		n_errors++;
		tally_and_finish();
	end
endmodule // tb
